// File: ufm_pkg.sv
/*
 * Shared constants and types for the flow-control and line-management block.
 * Assumes it is compiled before every design file that imports it.
 */
package ufm_pkg;

   // ----------------------------------------------------------------
   // Field widths
   // ----------------------------------------------------------------
   localparam int CHAR_W     = 8;    // Width of one received character.
   localparam int FREE_W     = 9;    // Width of the receive FIFO free-space count.
   localparam int DELAY_W    = 4;    // Width of the turn-around delay field.
   localparam int MODE_W     = 3;    // Width of the pin and flow mode fields.
   localparam int FIFO_DEPTH = 8;    // Words held by the receive path buffer.

   // ----------------------------------------------------------------
   // Pin-function modes
   // ----------------------------------------------------------------
   localparam logic [MODE_W-1:0] PIN_GENERAL = 3'h0;  // Plain general pins.
   localparam logic [MODE_W-1:0] PIN_RTS_CTS = 3'h1;  // Pins five and four as RTS/CTS.
   localparam logic [MODE_W-1:0] PIN_DTR_DSR = 3'h2;  // Pins three and two as DTR/DSR.
   localparam logic [MODE_W-1:0] PIN_DIR_A   = 3'h3;  // Pin five as RS-485 direction.
   localparam logic [MODE_W-1:0] PIN_DIR_B   = 3'h4;  // Pin five as RS-485 direction.

   // ----------------------------------------------------------------
   // Flow modes
   // ----------------------------------------------------------------
   localparam logic [MODE_W-1:0] FLOW_NONE     = 3'h0;  // No flow control.
   localparam logic [MODE_W-1:0] FLOW_HW       = 3'h1;  // Hardware handshake lines.
   localparam logic [MODE_W-1:0] FLOW_SW       = 3'h2;  // In-band stop and resume characters.
   localparam logic [MODE_W-1:0] FLOW_MD_FREE  = 3'h3;  // Multidrop, transmit always.
   localparam logic [MODE_W-1:0] FLOW_MD_GATED = 3'h4;  // Multidrop, transmit after match.

   // ----------------------------------------------------------------
   // Counts, watermarks and reset values
   // ----------------------------------------------------------------
   localparam logic [DELAY_W-1:0] DELAY_NONE = 4'h0;   // No turn-around delay.
   localparam logic [DELAY_W-1:0] DELAY_LAST = 4'h1;   // Final bit time of the delay.
   localparam logic [FREE_W-1:0]  RX_LOW_WM  = 9'h010; // Stop the remote below this room.
   localparam logic [FREE_W-1:0]  RX_HIGH_WM = 9'h020; // Release the remote above this room.
   localparam logic               RST_LOW    = 1'h0;   // Reset level of cleared flags.
   localparam logic               RST_HIGH   = 1'h1;   // Reset level of set flags.

   // Direction controller states.
   typedef enum logic [1:0] {
      DIR_IDLE = 2'b00,   // Direction released.
      DIR_LEAD = 2'b01,   // Direction asserted, no data yet.
      DIR_SEND = 2'b10,   // Characters being shifted out.
      DIR_HOLD = 2'b11    // Turn-around delay running.
   } ufm_dir_state_t;

   // Static line configuration.
   typedef struct packed {
      logic                half_duplex;       // Blank receive while sending.
      logic [MODE_W-1:0]   flow_mode;         // Flow mode field.
      logic                dir_invert;        // Direction output active low when set.
      logic [MODE_W-1:0]   pin_mode;          // Pin-function field.
      logic [DELAY_W-1:0]  turnaround_delay;  // Bit times to hold direction.
      logic [CHAR_W-1:0]   resume_char;       // Resume character or unicast address.
      logic [CHAR_W-1:0]   stop_char;         // Stop character or multicast address.
   } ufm_cfg_t;

   // One character from the receive shift register.
   typedef struct packed {
      logic                ninth;  // Ninth or parity bit, address flag.
      logic [CHAR_W-1:0]   data;   // Character value.
   } ufm_rx_char_t;

endpackage : ufm_pkg

// File: ufm_flow_ctrl.sv
/*
 * Flow control, RS-485 direction, multidrop matching, half-duplex blanking,
 * and the small receive buffer that feeds the receive FIFO.
 * Assumes a transmit shift register that raises tx_busy the cycle after
 * tx_start and drops it after the final stop bit, and a baud generator that
 * gives bit_tick once per bit time. All inputs are synchronous to mclk.
 */

// --------------------------------------------------------------------
// Receive buffer
// --------------------------------------------------------------------
module ufm_fifo
   import ufm_pkg::*;
#(
   parameter int WIDTH = CHAR_W,      // Word width.
   parameter int DEPTH = FIFO_DEPTH   // Number of words.
) (
   // Clock and control
   input  wire logic             mclk,
   input  wire logic             srst,
   input  wire logic             clk_en,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage words.
   logic [AW-1:0]    wr_idx_reg;       // Next word to write.
   logic [AW-1:0]    rd_idx_reg;       // Next word to read.
   logic [AW:0]      count_reg;        // Words held.
   logic             push;             // Word accepted this cycle.
   logic             pop;              // Word delivered this cycle.

   // Full and empty come straight from the count.
   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_idx_reg];
   assign push      = clk_en & in_valid & in_ready;
   assign pop       = clk_en & out_valid & out_ready;

   // Stores the incoming word.
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_reg[wr_idx_reg] <= in_data;
      end
   end

   // Advances the indices, wrapping at the last word.
   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_idx_reg <= '0;
         rd_idx_reg <= '0;
      end else begin
         if (push) begin
            wr_idx_reg <= (wr_idx_reg == AW'(DEPTH-1)) ? '0 : wr_idx_reg + 1'b1;
         end
         if (pop) begin
            rd_idx_reg <= (rd_idx_reg == AW'(DEPTH-1)) ? '0 : rd_idx_reg + 1'b1;
         end
      end
   end

   // Tracks the number of words held.
   always_ff @(posedge mclk) begin
      if (srst) begin
         count_reg <= '0;
      end else if (push && !pop) begin
         count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
         count_reg <= count_reg - 1'b1;
      end
   end
endmodule // ufm_fifo

module ufm_flow_ctrl
   import ufm_pkg::*;
#(
   parameter logic [FREE_W-1:0] LOW_WM  = RX_LOW_WM,   // Stop level.
   parameter logic [FREE_W-1:0] HIGH_WM = RX_HIGH_WM,  // Release level.
   parameter int                DEPTH   = FIFO_DEPTH   // Buffer words.
) (
   // Clock and control
   input  wire logic               mclk,
   input  wire logic               srst,
   input  wire logic               clk_en,
   // Configuration
   input  wire ufm_cfg_t           cfg,
   input  wire logic               bit_tick,
   // Transmit shift register
   input  wire logic               tx_data_avail,
   input  wire logic               tx_busy,
   output logic                    tx_start,
   // Receive shift register
   input  wire logic               rx_char_valid,
   input  wire ufm_rx_char_t       rx_char,
   output logic                    rx_char_ready,
   output logic                    rx_line_blank,
   output logic                    rx_enable,
   // Receive FIFO side
   input  wire logic [FREE_W-1:0]  rx_free,
   output logic                    rxq_valid,
   input  wire logic               rxq_ready,
   output logic [CHAR_W-1:0]       rxq_data,
   // General pin five
   input  wire logic               general_pin_five_in,
   output logic                    general_pin_five_direction_out,
   output logic                    general_pin_five_oe,
   // General pin four
   input  wire logic               general_pin_four_in,
   output logic                    general_pin_four_out,
   output logic                    general_pin_four_oe,
   // General pin three
   input  wire logic               general_pin_three_in,
   output logic                    general_pin_three_out,
   output logic                    general_pin_three_oe,
   // General pin two
   input  wire logic               general_pin_two_in,
   output logic                    general_pin_two_out,
   output logic                    general_pin_two_oe
);

   // ----------------------------------------------------------------
   // Mode decoding
   // ----------------------------------------------------------------

   // True for the pin modes that drive RS-485 direction.
   function automatic logic is_dir_mode(input logic [MODE_W-1:0] m);
      return (m == PIN_DIR_A) || (m == PIN_DIR_B);
   endfunction

   // True for the multidrop flow modes.
   function automatic logic is_md_mode(input logic [MODE_W-1:0] m);
      return (m == FLOW_MD_FREE) || (m == FLOW_MD_GATED);
   endfunction

   logic dir_on;      // RS-485 direction control active.
   logic rts_on;      // RTS/CTS handshake active.
   logic dtr_on;      // DTR/DSR handshake active.
   logic sw_on;       // Stop and resume characters active.
   logic md_on;       // Multidrop address matching active.

   assign dir_on = is_dir_mode(cfg.pin_mode);
   assign rts_on = (cfg.flow_mode == FLOW_HW) && (cfg.pin_mode == PIN_RTS_CTS);
   assign dtr_on = (cfg.flow_mode == FLOW_HW) && (cfg.pin_mode == PIN_DTR_DSR);
   assign sw_on  = (cfg.flow_mode == FLOW_SW);
   assign md_on  = is_md_mode(cfg.flow_mode);

   // ----------------------------------------------------------------
   // State and shared terms
   // ----------------------------------------------------------------
   ufm_dir_state_t     dir_state_reg;   // Direction controller state.
   ufm_dir_state_t     dir_state_next;  // Its next value.
   logic [DELAY_W-1:0] hold_cnt_reg;    // Bit times left in the hold.
   logic               start_reg;       // Start issued last cycle.
   logic               halt_reg;        // Halted by a stop character.
   logic               rx_on_reg;       // Receiver enabled in multidrop.
   logic               matched_reg;     // Address matched since last miss.
   logic               flow_stop_reg;   // Remote asked to stop.
   logic               flow_stop_next;  // Its next value.
   logic               sending;         // A character is in flight.
   logic               peer_pause;      // Remote handshake says wait.
   logic               tx_gate;         // Transmission permitted.
   logic               want;            // Data ready and permitted.
   logic               slot;            // Direction allows a start.
   logic               rx_take;         // Character accepted from the line.
   logic               is_addr;         // Character is an address.
   logic               addr_hit;        // Address equals a node address.
   logic               rx_store;        // Character goes to the buffer.

   assign sending = tx_busy | start_reg;

   // ----------------------------------------------------------------
   // Transmit permission
   // ----------------------------------------------------------------

   // Handshake inputs are active low, so a high level means wait.
   assign peer_pause = (rts_on & general_pin_four_in)
                     | (dtr_on & general_pin_two_in);

   // Halts only block new starts, so the character in flight finishes.
   assign tx_gate = !peer_pause
                  & !(sw_on & halt_reg)
                  & !((cfg.flow_mode == FLOW_MD_GATED) & !matched_reg);
   assign want    = tx_data_avail & tx_gate;

   // With direction control, data may start only once direction is up.
   assign slot = !dir_on
               | (dir_state_reg == DIR_SEND)
               | (dir_state_reg == DIR_HOLD);

   // Start pulse; start_reg covers the cycle before tx_busy rises.
   assign tx_start = clk_en & want & !sending & slot;

   // Remembers a start until the shift register reports busy.
   always_ff @(posedge mclk) begin
      if (srst) begin
         start_reg <= RST_LOW;
      end else if (clk_en) begin
         start_reg <= tx_start;
      end
   end

   // ----------------------------------------------------------------
   // RS-485 direction controller
   // ----------------------------------------------------------------

   // Raises direction a cycle ahead of data and holds it past the end.
   always_comb begin
      dir_state_next = dir_state_reg;
      case (dir_state_reg)
         DIR_IDLE: begin
            // Raise direction first; data follows next cycle.
            if (want && !sending) begin
               dir_state_next = DIR_LEAD;
            end
         end
         DIR_LEAD: begin
            // Direction has stood for one cycle.
            dir_state_next = DIR_SEND;
         end
         DIR_SEND: begin
            // Last stop bit done and nothing more to send.
            if (!sending && !want) begin
               if (cfg.turnaround_delay == DELAY_NONE) begin
                  dir_state_next = DIR_IDLE;
               end else begin
                  dir_state_next = DIR_HOLD;
               end
            end
         end
         DIR_HOLD: begin
            // New data reuses the raised direction.
            if (want) begin
               dir_state_next = DIR_SEND;
            end else if (bit_tick && hold_cnt_reg <= DELAY_LAST) begin
               dir_state_next = DIR_IDLE;
            end
         end
         default: begin
            dir_state_next = DIR_IDLE;
         end
      endcase
      // Outside direction modes the controller rests.
      if (!dir_on) begin
         dir_state_next = DIR_IDLE;
      end
   end

   // Registers the direction state.
   always_ff @(posedge mclk) begin
      if (srst) begin
         dir_state_reg <= DIR_IDLE;
      end else if (clk_en) begin
         dir_state_reg <= dir_state_next;
      end
   end

   // Counts the turn-around delay in bit times.
   always_ff @(posedge mclk) begin
      if (srst) begin
         hold_cnt_reg <= DELAY_NONE;
      end else if (clk_en) begin
         if (dir_state_reg == DIR_SEND) begin
            hold_cnt_reg <= cfg.turnaround_delay;
         end else if (dir_state_reg == DIR_HOLD && bit_tick) begin
            hold_cnt_reg <= hold_cnt_reg - DELAY_LAST;
         end
      end
   end

   // ----------------------------------------------------------------
   // Receive side: blanking, matching and storing
   // ----------------------------------------------------------------

   // In half-duplex the receiver ignores the line while sending.
   assign rx_line_blank = cfg.half_duplex & sending;
   assign rx_take       = rx_char_valid & !rx_line_blank;

   assign is_addr  = md_on & rx_char.ninth;
   assign addr_hit = (rx_char.data == cfg.resume_char)
                   | (rx_char.data == cfg.stop_char);

   // Addresses are never stored; data only while the receiver is on.
   assign rx_store  = rx_take & (!md_on | (!rx_char.ninth & rx_on_reg));
   assign rx_enable = !md_on | rx_on_reg;

   // Enables or disables reception on each address byte.
   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_on_reg   <= RST_HIGH;
         matched_reg <= RST_LOW;
      end else if (clk_en) begin
         if (!md_on) begin
            rx_on_reg   <= RST_HIGH;
            matched_reg <= RST_LOW;
         end else if (rx_take && is_addr) begin
            // Addresses are examined even while disabled.
            rx_on_reg   <= addr_hit;
            matched_reg <= addr_hit;
         end
      end
   end

   // Stop and resume characters; stop wins if both registers agree.
   always_ff @(posedge mclk) begin
      if (srst) begin
         halt_reg <= RST_LOW;
      end else if (clk_en) begin
         if (!sw_on) begin
            halt_reg <= RST_LOW;
         end else if (rx_take && rx_char.data == cfg.stop_char) begin
            halt_reg <= RST_HIGH;
         end else if (rx_take && rx_char.data == cfg.resume_char) begin
            halt_reg <= RST_LOW;
         end
      end
   end

   // ----------------------------------------------------------------
   // Receive buffer
   // ----------------------------------------------------------------

   // Its ready goes back to the receive shift register as back-pressure.
   ufm_fifo #(
      .WIDTH (CHAR_W),
      .DEPTH (DEPTH)
   ) u_rx_buf (
      .mclk      (mclk),
      .srst      (srst),
      .clk_en    (clk_en),
      .in_valid  (rx_store),
      .in_ready  (rx_char_ready),
      .in_data   (rx_char.data),
      .out_valid (rxq_valid),
      .out_ready (rxq_ready),
      .out_data  (rxq_data)
   );

   // ----------------------------------------------------------------
   // Receive-room handshake
   // ----------------------------------------------------------------

   // Two watermarks give hysteresis so the line does not chatter.
   always_comb begin
      flow_stop_next = flow_stop_reg;
      if (rx_free < LOW_WM) begin
         flow_stop_next = RST_HIGH;
      end else if (rx_free > HIGH_WM) begin
         flow_stop_next = RST_LOW;
      end
   end

   // Registers the stop request.
   always_ff @(posedge mclk) begin
      if (srst) begin
         flow_stop_reg <= RST_LOW;
      end else if (clk_en) begin
         flow_stop_reg <= flow_stop_next;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------

   // Pin outputs are registered from next-state values.
   always_ff @(posedge mclk) begin
      if (srst) begin
         general_pin_five_direction_out <= RST_LOW;
         general_pin_five_oe            <= RST_LOW;
         general_pin_three_out          <= RST_LOW;
         general_pin_three_oe           <= RST_LOW;
      end else if (clk_en) begin
         if (dir_on) begin
            // Direction is active high unless the invert bit is set.
            general_pin_five_direction_out <=
               (dir_state_next != DIR_IDLE) ^ cfg.dir_invert;
            general_pin_five_oe <= RST_HIGH;
         end else if (cfg.pin_mode == PIN_RTS_CTS) begin
            // RTS is active low: high asks the remote to stop.
            general_pin_five_direction_out <= rts_on & flow_stop_next;
            general_pin_five_oe            <= RST_HIGH;
         end else begin
            general_pin_five_direction_out <= RST_LOW;
            general_pin_five_oe            <= RST_LOW;
         end
         // DTR is active low, like RTS.
         general_pin_three_out <= dtr_on & flow_stop_next;
         general_pin_three_oe  <= (cfg.pin_mode == PIN_DTR_DSR);
      end
   end

   // Pins four and two are inputs only in these modes.
   assign general_pin_four_out = RST_LOW;
   assign general_pin_four_oe  = RST_LOW;
   assign general_pin_two_out  = RST_LOW;
   assign general_pin_two_oe   = RST_LOW;

endmodule // ufm_flow_ctrl

// File: ufm_flow_ctrl_props.sv
/* Port checker for ufm_flow_ctrl: flow pins, direction, blanking and storage.
   Assumes every port is synchronous to mclk; the bind at the foot attaches it. */
module ufm_flow_ctrl_props
   import ufm_pkg::*;
#(
   parameter logic [FREE_W-1:0] LOW_WM  = RX_LOW_WM,   // Stop level.
   parameter logic [FREE_W-1:0] HIGH_WM = RX_HIGH_WM   // Release level.
) (
   // Watched ports
   input wire logic              mclk, srst, clk_en, tx_busy, tx_start, rx_char_valid, rx_line_blank, rx_enable,
   input wire logic              rxq_valid, general_pin_four_in, general_pin_two_in,
   input wire logic              general_pin_five_direction_out, general_pin_three_out, general_pin_five_oe,
   input wire ufm_cfg_t          cfg,
   input wire ufm_rx_char_t      rx_char,
   input wire logic [FREE_W-1:0] rx_free,
   input wire logic [CHAR_W-1:0] rxq_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Mode decodes
   // ------------------------------------------------------------
   wire logic hw1  = clk_en && cfg.pin_mode == PIN_RTS_CTS && cfg.flow_mode == FLOW_HW;  // RTS/CTS live.
   wire logic hw2  = clk_en && cfg.pin_mode == PIN_DTR_DSR && cfg.flow_mode == FLOW_HW;  // DTR/DSR live.
   wire logic rs   = cfg.pin_mode inside {PIN_DIR_A, PIN_DIR_B};                        // Direction on pin five.
   wire logic md   = cfg.flow_mode inside {FLOW_MD_FREE, FLOW_MD_GATED};                // Address matching.
   wire logic take = clk_en && rx_char_valid && !rx_line_blank && !rxq_valid;           // Char into empty buffer.
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   rts_stop_a: assert property (hw1 && rx_free < LOW_WM |=> general_pin_five_direction_out)
      else $error("rts not dropped");
   rts_go_a: assert property (hw1 && rx_free > HIGH_WM |=> !general_pin_five_direction_out)
      else $error("rts not restored");
   dtr_stop_a: assert property (hw2 && rx_free < LOW_WM |=> general_pin_three_out)
      else $error("dtr not dropped");
   cts_pause_a: assert property (tx_start |-> !(hw1 && general_pin_four_in)) else $error("start against cts");
   dsr_pause_a: assert property (tx_start |-> !(hw2 && general_pin_two_in)) else $error("start against dsr");
   dir_lead_a: assert property (tx_start && rs |-> general_pin_five_direction_out != cfg.dir_invert)
      else $error("direction late");
   blank_cause_a: assert property (rx_line_blank |-> cfg.half_duplex) else $error("blank in full duplex");
   blank_busy_a: assert property (cfg.half_duplex && tx_busy |-> rx_line_blank) else $error("no blank");
   data_store_a: assert property (take && rx_enable && !rx_char.ninth |=> rxq_valid && rxq_data == $past(rx_char.data))
      else $error("data not stored");
   addr_drop_a: assert property (take && md && rx_char.ninth |=> !rxq_valid) else $error("address stored");
   pin_drive_a: assert property ((clk_en && rs) || hw1 |=> general_pin_five_oe)
      else $error("pin five undriven");
   cover property (tx_start && rs);
   cover property ($fell(rx_enable));
   cover property (rx_line_blank && rx_char_valid);
endmodule // ufm_flow_ctrl_props

bind ufm_flow_ctrl ufm_flow_ctrl_props #(.LOW_WM(LOW_WM), .HIGH_WM(HIGH_WM)) props_i (.*);

// File: ufm_far_node.sv
/* Far-side model: baud ticks and the transmit shift register that sends chars out.
   Assumes mclk and srst from the bench; a char lasts ten bit times. */
module ufm_far_node (
   // Clock, reset and start request
   input wire logic mclk, srst, tx_start,
   // Timing back to the block
   output logic     bit_tick, tx_busy,
   output int       sent
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div_reg;   // Four clocks per bit time.
   logic [3:0] bits_reg;  // Bits left in the char.
   // Bit-time divider.
   always_ff @(posedge mclk) begin
      div_reg <= srst ? 2'h0 : div_reg + 2'h1;
      bit_tick <= !srst && div_reg == 2'h3;
   end
   // Busy rises after a start and falls after the stop bit.
   always_ff @(posedge mclk) begin
      if (srst) begin
         tx_busy <= 1'h0;
         sent <= 0;
      end else if (tx_start) begin
         tx_busy <= 1'h1;
         bits_reg <= 4'hA;
         sent <= sent + 1;
      end else if (bit_tick && tx_busy) begin
         bits_reg <= bits_reg - 4'h1;
         tx_busy <= bits_reg != 4'h1;
      end
   end
endmodule // ufm_far_node

// File: ufm_flow_ctrl_test.sv
/* Self-checking bench for ufm_flow_ctrl: flow pins, halts, direction, multidrop, buffer.
   Assumes the far-node model and the bound checker. */
module ufm_flow_ctrl_test
   import ufm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, srst = 1, tx_data_avail = 0, rx_char_valid = 0, cts = 0, dsr = 0, pop = 1;
   logic bit_tick, tx_busy, tx_start, pin5, pin3, rxq_valid, rx_enable, rdy;
   ufm_cfg_t cfg = '0;
   ufm_rx_char_t rx_char = '0;
   logic [FREE_W-1:0] room = 9'h100, wm[4] = '{RX_LOW_WM - 9'h1, RX_HIGH_WM, RX_HIGH_WM + 9'h1, RX_LOW_WM};
   logic [CHAR_W-1:0] rxq_data;
   int sent, s0, fails = 0, checks_done = 0;
   initial forever #4 mclk = ~mclk;
   ufm_far_node far (.mclk, .srst, .tx_start, .bit_tick, .tx_busy, .sent);
   ufm_flow_ctrl uut (.mclk, .srst, .clk_en(1'h1), .cfg, .bit_tick, .tx_data_avail, .tx_busy, .tx_start,
      .rx_char_valid, .rx_char, .rx_char_ready(rdy), .rx_line_blank(), .rx_enable, .rx_free(room), .rxq_valid,
      .rxq_ready(pop), .rxq_data, .general_pin_five_in(1'h0), .general_pin_five_direction_out(pin5),
      .general_pin_five_oe(), .general_pin_four_in(cts), .general_pin_four_out(), .general_pin_four_oe(),
      .general_pin_three_in(1'h0), .general_pin_three_out(pin3), .general_pin_three_oe(),
      .general_pin_two_in(dsr), .general_pin_two_out(), .general_pin_two_oe());
   task automatic wrap_up();
      if (fails == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(logic [8:0] seen, logic [8:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic settle(int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic mode(logic [2:0] p, logic [2:0] f, logic [3:0] dl, logic inv, logic hd);
      @(posedge mclk) cfg <= '{hd, f, inv, p, dl, 8'h11, 8'h13};
   endtask
   task automatic rx(logic nin, logic [7:0] d);
      @(posedge mclk) rx_char <= {nin, d};
      rx_char_valid <= 1'h1;
      @(posedge mclk) rx_char_valid <= 1'h0;
      settle(3);
   endtask
   task automatic send(logic on);
      @(posedge mclk) tx_data_avail <= on;
      s0 = sent;
      for (int n = 0; n < 400 && (on ? sent == s0 : tx_busy || n < 2); n++) @(negedge mclk);
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'h0;
      for (int p = 1; p < 3; p++) begin
         mode(3'(p), FLOW_HW, 4'h0, 1'h0, 1'h0);
         foreach (wm[i]) begin
            @(posedge mclk) room <= wm[i];
            settle(2);
            check(p == 1 ? pin5 : pin3, 9'(i < 2));
         end
         @(posedge mclk) {cts, dsr, tx_data_avail} <= 3'h7;
         s0 = sent;
         settle(80);
         check(9'(sent), 9'(s0));
         @(posedge mclk) {cts, dsr} <= 2'h0;
         send(1'h1);
         check(9'(sent > s0), 9'h1);
         send(1'h0);
      end
      for (int f = 0; f < 3; f += 2) begin
         mode(PIN_GENERAL, 3'(f), 4'h0, 1'h0, 1'h0);
         @(posedge mclk) tx_data_avail <= 1'h1;
         rx(1'h0, 8'h13);
         s0 = sent;
         settle(120);
         check(9'(sent == s0), 9'(f == 2));
         rx(1'h0, 8'h11);
         send(1'h1);
         check(9'(sent > s0), 9'h1);
         send(1'h0);
      end
      @(posedge mclk) pop <= 1'h0;
      for (int k = 0; k < 4; k++) begin
         mode(k[1] ? PIN_DIR_B : PIN_DIR_A, FLOW_MD_FREE, k[0] ? 4'h3 : 4'h0, k[1], 1'h1);
         send(1'h1);
         rx(1'h0, 8'h77);
         send(1'h0);
         settle(1);
         check(pin5, 9'(k[0] ^ k[1]));
         settle(20);
         check(pin5, 9'(k[1]));
      end
      check(rxq_valid, 9'h0);
      mode(PIN_DIR_A, FLOW_MD_GATED, 4'h0, 1'h0, 1'h0);
      @(posedge mclk) {pop, tx_data_avail} <= 2'h1;
      rx(1'h1, 8'h55);
      check(rx_enable, 9'h0);
      rx(1'h0, 8'h22);
      check(9'(sent), 9'(s0));
      rx(1'h1, 8'h13);
      check({rxq_valid, rx_enable}, 9'h1);
      rx(1'h1, 8'h11);
      send(1'h1);
      check(9'(sent > s0), 9'h1);
      send(1'h0);
      for (int i = 0; i < 9; i++) rx(1'h0, 8'h30 + 8'(i));
      check(rdy, 9'h0);
      for (int i = 0; i < 9; i++) begin
         check(i < 8 ? {rxq_valid, rxq_data} : 9'(rxq_valid), i < 8 ? {1'h1, 8'h30 + 8'(i)} : 9'h0);
         @(posedge mclk) pop <= 1'h1;
         @(posedge mclk) pop <= 1'h0;
         settle(1);
      end
      wrap_up();
   end
   initial begin
      repeat (30000) @(posedge mclk);
      fails++;
      wrap_up();
   end
endmodule // ufm_flow_ctrl_test
